/* rtl/ssc_pkg.sv */
// Shared constants for the synchronous serial controller core
`default_nettype none
package ssc_pkg;
  // ==================================================
  // Register bus
  localparam int ADDR_W = 8;               // Byte address width
  localparam int DATA_W = 32;              // Bus data width
  localparam logic [7:0] OFS_CTRL = 8'h00;          // Enables
  localparam logic [7:0] OFS_CLK_MODE = 8'h04;      // Divider ratio
  localparam logic [7:0] OFS_RX_CLK_MODE = 8'h10;   // Rx clock and start
  localparam logic [7:0] OFS_RX_FRAME_MODE = 8'h14; // Rx compare pattern
  localparam logic [7:0] OFS_TX_CLK_MODE = 8'h18;   // Tx clock and start
  localparam logic [7:0] OFS_TX_FRAME_MODE = 8'h1c; // Tx idle data level
  localparam logic [7:0] OFS_RX_HOLD = 8'h20;       // Received word
  localparam logic [7:0] OFS_TX_HOLD = 8'h24;       // Word to send
  localparam logic [7:0] OFS_STATUS = 8'h40;        // Flags
  localparam logic [7:0] OFS_IRQ_MASK = 8'h4c;      // Flag enables
  localparam logic [31:0] RST_REG = 32'h0000_0000;  // All registers
  // ==================================================
  // Field layout
  localparam int DIV_W = 12;               // Divider ratio width
  localparam int CTRL_RX_EN = 0;           // Receiver enable bit
  localparam int CTRL_TX_EN = 1;           // Transmitter enable bit
  localparam int MODE_W = 12;              // Clock mode register width
  localparam int CKS_LSB = 0;              // Clock source, 2 bits
  localparam int CKO_LSB = 2;              // Clock output mode, 2 bits
  localparam int CKI_BIT = 4;              // Internal clock invert
  localparam int START_LSB = 8;            // Start selection, 4 bits
  localparam int PAT_W = 8;                // Compare pattern width
  localparam int DEF_BIT = 0;              // Tx idle level bit
  localparam int ST_W = 8;                 // Status width
  localparam int ST_TX_FREE = 0;           // Holding free
  localparam int ST_TX_EMPTY = 1;          // Holding and shifter empty
  localparam int ST_RX_AVAIL = 4;          // Word available
  localparam int ST_RX_OVR = 5;            // Overrun
  // ==================================================
  // Encodings
  localparam logic [1:0] CKS_DIV = 2'h0;   // Divided clock
  localparam logic [1:0] CKS_OTHER = 2'h1; // Other side clock
  localparam logic [1:0] CKS_PIN = 2'h2;   // Own clock pin
  localparam logic [1:0] CKO_NONE = 2'h0;  // Pin is an input
  localparam logic [1:0] CKO_CONT = 2'h1;  // Driven always
  localparam logic [1:0] CKO_XFER = 2'h2;  // Driven during transfer
  localparam logic [3:0] ST_CONT = 4'h0;   // Continuous
  localparam logic [3:0] ST_OTHER = 4'h1;  // With other side
  localparam logic [3:0] ST_LOW = 4'h2;    // Frame sync low
  localparam logic [3:0] ST_HIGH = 4'h3;   // Frame sync high
  localparam logic [3:0] ST_FALL = 4'h4;   // Falling edge
  localparam logic [3:0] ST_RISE = 4'h5;   // Rising edge
  localparam logic [3:0] ST_LEVEL = 4'h6;  // Any level change
  localparam logic [3:0] ST_EDGE = 4'h7;   // Any edge
  localparam logic [3:0] ST_CMP = 4'h8;    // Pattern match, rx only
endpackage
`default_nettype wire

/* rtl/ssc_clk_div.sv */
// Common master clock divider with 50% duty output
`default_nettype none
module ssc_clk_div
  import ssc_pkg::*;
(
  input wire logic clk,                // Master clock
  input wire logic reset_n,            // Async reset, active low
  input wire logic [DIV_W-1:0] ratio,  // Half period in clocks
  output logic div_clk                 // Divided clock level
);
  // ==================================================
  // State
  typedef struct packed {
    logic [DIV_W-1:0] cnt;  // Clocks spent in this level
    logic level;            // Output level
  } ssc_div_t;
  ssc_div_t s, n;

  // Next state: toggle after ratio clocks, idle at zero
  always_comb begin
    n = s;
    if (ratio == '0) begin           // Inactive
      n.cnt = '0;
      n.level = 1'b0;
    end else if (s.cnt >= ratio - 1'b1) begin  // Level done
      n.cnt = '0;
      n.level = ~s.level;
    end else begin
      n.cnt = s.cnt + 1'b1;
    end
  end

  // Register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign div_clk = s.level;

  property p_div_off;
    @(posedge clk) disable iff (!reset_n) (ratio == '0) |=> !div_clk;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider runs at ratio zero");

  property p_div_level;
    @(posedge clk) disable iff (!reset_n)
      ($changed(div_clk) && $stable(ratio) && ratio == $past(ratio, 2) && ratio != '0) |-> ($past(s.cnt) == ratio - 1'b1);
  endproperty
  a_div_level: assert property (p_div_level) else $error("divided level has wrong length");
endmodule
`default_nettype wire

/* rtl/ssc_start_det.sv */
// Start event selection for one side
`default_nettype none
module ssc_start_det
  import ssc_pkg::*;
(
  input wire logic [3:0] sel,   // Start selection
  input wire logic strobe,      // Bit clock edge of this side
  input wire logic fs,          // Frame sync now
  input wire logic fs_prev,     // Frame sync at last edge
  input wire logic other,       // Other side started
  input wire logic cont,        // Continuous condition
  input wire logic cmp_hit,     // Pattern match
  output logic go               // Start now
);
  // Decode the chosen event
  always_comb begin
    case (sel)
      ST_CONT: go = strobe & cont;
      ST_OTHER: go = other;
      ST_LOW: go = strobe & !fs;
      ST_HIGH: go = strobe & fs;
      ST_FALL: go = strobe & fs_prev & !fs;
      ST_RISE: go = strobe & !fs_prev & fs;
      ST_LEVEL, ST_EDGE: go = strobe & (fs ^ fs_prev);
      ST_CMP: go = strobe & cmp_hit;
      default: go = 1'b0;       // Unused codes never start
    endcase
  end
endmodule
`default_nettype wire

/* rtl/ssc_core.sv */
// Synchronous serial controller core: clocks, start, tx and rx paths
//
// What this block does
// - Twelve-bit divider ratio, divide up to 8190
// - Ratio zero keeps the divider idle
// - Each divided level lasts ratio master clocks
// - Divided clock duty is 50% while a nonzero ratio is held
// - Divided clock feeds both transmitter and receiver
// - Tx clock from pin, rx clock, divider
// - Rx clock from pin, tx clock, divider
// - Inversion affects internal clock, not pins
// - Tx clock pin driven always or during transfer
// - Rx clock pin driven always or during transfer
// - Frame begins on its configured start event
// - Tx empty when holding and shifter empty
// - Load into shifter sets tx holding free
// - Full rx shifter copies to holding, flags
// - Unread word overwritten, overrun flag set
// - Continuous start on write or enable
// - Frame sync edge, level or other side start
// - Receiver may start on pattern match
// - Sides independent, may borrow clock or start
// - Interrupt when unmasked status flag pending
`default_nettype none
module ssc_core
  import ssc_pkg::*;
#(
  parameter int WORD_BITS = 8          // Bits per data word
) (
  input wire logic clk,                // Master clock, 40 MHz
  input wire logic reset_n,            // Async reset, active low
  input wire logic [ADDR_W-1:0] addr,  // Register byte address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic wr,                 // Write strobe
  input wire logic rd,                 // Read strobe
  output logic [DATA_W-1:0] rdata,     // Read data, cycle after rd
  output logic irq,                    // Interrupt, active high
  input wire logic tx_clock_pin_in,    // Tx clock pin level
  output logic tx_clock_pin_out,       // Tx clock pin drive
  output logic tx_clock_pin_oe_n,      // Tx clock pin enable, low drives
  input wire logic rx_clock_pin_in,    // Rx clock pin level
  output logic rx_clock_pin_out,       // Rx clock pin drive
  output logic rx_clock_pin_oe_n,      // Rx clock pin enable, low drives
  input wire logic tx_frame_sync_pin,  // Tx frame sync input
  input wire logic rx_frame_sync_pin,  // Rx frame sync input
  input wire logic rx_data_pin,        // Serial data in
  output logic tx_data_pin             // Serial data out
);
  localparam int CNT_W = $clog2(WORD_BITS + 1);  // Bit counter width

  // ==================================================
  // State
  typedef enum logic {TX_IDLE, TX_SHIFT} ssc_tx_state_t;
  typedef enum logic {RX_IDLE, RX_RECV} ssc_rx_state_t;
  typedef struct packed {
    logic [4:0] sync_a;            // First sync stage
    logic [4:0] sync_b;            // Second sync stage
    logic [1:0] ctrl;              // Enables
    logic [DIV_W-1:0] div_ratio;   // Divider ratio
    logic [MODE_W-1:0] tx_mode;    // Tx clock mode
    logic [MODE_W-1:0] rx_mode;    // Rx clock mode
    logic [PAT_W-1:0] tx_frame;    // Tx frame mode
    logic [PAT_W-1:0] rx_frame;    // Rx compare pattern
    logic [ST_W-1:0] irq_mask;     // Interrupt enables
    logic tx_sel;                  // Selected tx clock
    logic rx_sel;                  // Selected rx clock
    logic tx_int_prev;             // Last internal tx clock
    logic rx_int_prev;             // Last internal rx clock
    logic tx_fs_prev;              // Tx frame sync at last edge
    logic rx_fs_prev;              // Rx frame sync at last edge
    ssc_tx_state_t tx_state;       // Tx sequencer
    logic [WORD_BITS-1:0] tx_hold; // Tx holding register
    logic [WORD_BITS-1:0] tx_shift;// Tx shifter
    logic tx_full;                 // Holding occupied
    logic [CNT_W-1:0] tx_cnt;      // Bits left after current
    logic tx_data;                 // Data pin level
    logic tx_start_q;              // Tx started, for rx
    ssc_rx_state_t rx_state;       // Rx sequencer
    logic [WORD_BITS-1:0] rx_shift;// Rx shifter
    logic [WORD_BITS-1:0] rx_hold; // Rx holding register
    logic [CNT_W-1:0] rx_cnt;      // Bits still to sample
    logic rx_avail;                // Word available
    logic rx_ovr;                  // Overrun
    logic [PAT_W-1:0] rx_hist;     // Last bits seen
    logic rx_start_q;              // Rx started, for tx
    logic [DATA_W-1:0] rdata;      // Read data
  } ssc_core_t;
  ssc_core_t s, n;

  logic div_clk;                   // Divided clock
  logic tx_int, rx_int;            // Internal clocks after inversion
  logic tx_fall, rx_rise;          // Working edges
  logic tx_go, rx_go;              // Start detector outputs
  logic tx_start, rx_start;        // Qualified starts
  logic rx_done;                   // Word complete
  logic [WORD_BITS-1:0] rx_word;   // Completed word
  logic [PAT_W-1:0] hist_next;     // History with new bit
  logic rd_hold, rd_status;        // Clearing reads
  logic [ST_W-1:0] status_word;    // Status register view

  // ==================================================
  // Shared divider
  ssc_clk_div u_div (
    .clk(clk),
    .reset_n(reset_n),
    .ratio(s.div_ratio),
    .div_clk(div_clk)
  );

  // ==================================================
  // Start detectors
  ssc_start_det u_tx_start (
    .sel(s.tx_mode[START_LSB+:4]),
    .strobe(tx_fall),
    .fs(s.sync_b[2]),
    .fs_prev(s.tx_fs_prev),
    .other(s.rx_start_q),
    .cont(s.tx_full),
    .cmp_hit(1'b0),
    .go(tx_go)
  );

  ssc_start_det u_rx_start (
    .sel(s.rx_mode[START_LSB+:4]),
    .strobe(rx_rise),
    .fs(s.sync_b[3]),
    .fs_prev(s.rx_fs_prev),
    .other(s.tx_start_q),
    .cont(s.ctrl[CTRL_RX_EN]),
    .cmp_hit(hist_next == s.rx_frame),
    .go(rx_go)
  );

  // ==================================================
  // Edge and start terms
  always_comb begin
    tx_int = s.tx_sel ^ s.tx_mode[CKI_BIT];
    rx_int = s.rx_sel ^ s.rx_mode[CKI_BIT];
    tx_fall = !tx_int && s.tx_int_prev;
    rx_rise = rx_int && !s.rx_int_prev;
    hist_next = {s.rx_hist[PAT_W-2:0], s.sync_b[4]};
    // Transmit needs a word waiting and the side enabled
    tx_start = tx_go && s.tx_state == TX_IDLE && s.tx_full && s.ctrl[CTRL_TX_EN];
    rx_start = rx_go && s.rx_state == RX_IDLE && s.ctrl[CTRL_RX_EN];
    rx_done = rx_rise && s.rx_state == RX_RECV && s.rx_cnt == CNT_W'(1);
    rx_word = {s.rx_shift[WORD_BITS-2:0], s.sync_b[4]};
    rd_hold = rd && addr == OFS_RX_HOLD;
    rd_status = rd && addr == OFS_STATUS;
    status_word = '0;
    status_word[ST_TX_FREE] = !s.tx_full;
    status_word[ST_TX_EMPTY] = !s.tx_full && s.tx_state == TX_IDLE;
    status_word[ST_RX_AVAIL] = s.rx_avail;
    status_word[ST_RX_OVR] = s.rx_ovr;
  end

  // ==================================================
  // Next state
  always_comb begin
    n = s;
    // Pins through two flops
    n.sync_a = {rx_data_pin, rx_frame_sync_pin, tx_frame_sync_pin, rx_clock_pin_in, tx_clock_pin_in};
    n.sync_b = s.sync_a;
    // Tx clock source; other side is taken registered to avoid loops
    case (s.tx_mode[CKS_LSB+:2])
      CKS_OTHER: n.tx_sel = s.rx_sel;
      CKS_PIN: n.tx_sel = s.sync_b[0];
      default: n.tx_sel = div_clk;
    endcase
    // Rx clock source
    case (s.rx_mode[CKS_LSB+:2])
      CKS_OTHER: n.rx_sel = s.tx_sel;
      CKS_PIN: n.rx_sel = s.sync_b[1];
      default: n.rx_sel = div_clk;
    endcase
    n.tx_int_prev = tx_int;
    n.rx_int_prev = rx_int;
    if (tx_fall) begin          // Frame sync seen at tx edges
      n.tx_fs_prev = s.sync_b[2];
    end
    if (rx_rise) begin          // Frame sync seen at rx edges
      n.rx_fs_prev = s.sync_b[3];
    end
    n.tx_start_q = tx_start;
    n.rx_start_q = rx_start;

    // Transmitter: drive new bit on falling internal edge
    case (s.tx_state)
      TX_IDLE: begin
        if (tx_start) begin     // Load shifter from holding
          n.tx_shift = s.tx_hold;
          n.tx_full = 1'b0;
          n.tx_data = s.tx_hold[WORD_BITS-1];
          n.tx_cnt = CNT_W'(WORD_BITS - 1);
          n.tx_state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_fall) begin
          if (s.tx_cnt == '0) begin   // Last bit sent
            n.tx_state = TX_IDLE;
            n.tx_data = s.tx_frame[DEF_BIT];
          end else begin              // Next bit, MSB first
            n.tx_shift = {s.tx_shift[WORD_BITS-2:0], 1'b0};
            n.tx_data = s.tx_shift[WORD_BITS-2];
            n.tx_cnt = s.tx_cnt - 1'b1;
          end
        end
      end
      default: n.tx_state = TX_IDLE;
    endcase

    // Receiver: sample on rising internal edge
    if (rx_rise && s.ctrl[CTRL_RX_EN]) begin   // Pattern history
      n.rx_hist = hist_next;
    end
    case (s.rx_state)
      RX_IDLE: begin
        if (rx_start) begin     // Sample from next edge
          n.rx_cnt = CNT_W'(WORD_BITS);
          n.rx_state = RX_RECV;
        end
      end
      RX_RECV: begin
        if (rx_rise) begin
          n.rx_shift = rx_word;
          n.rx_cnt = s.rx_cnt - 1'b1;
          if (rx_done) begin    // Word complete
            n.rx_cnt = CNT_W'(WORD_BITS);
            if (!(s.rx_mode[START_LSB+:4] == ST_CONT && s.ctrl[CTRL_RX_EN])) begin
              n.rx_state = RX_IDLE;
            end
          end
        end
      end
      default: n.rx_state = RX_IDLE;
    endcase
    if (!s.ctrl[CTRL_RX_EN]) begin   // Disable stops reception
      n.rx_state = RX_IDLE;
    end

    // Register reads: clears first, hardware sets win after
    n.rdata = '0;
    if (rd) begin
      case (addr)
        OFS_CTRL: n.rdata = DATA_W'(s.ctrl);
        OFS_CLK_MODE: n.rdata = DATA_W'(s.div_ratio);
        OFS_RX_CLK_MODE: n.rdata = DATA_W'(s.rx_mode);
        OFS_RX_FRAME_MODE: n.rdata = DATA_W'(s.rx_frame);
        OFS_TX_CLK_MODE: n.rdata = DATA_W'(s.tx_mode);
        OFS_TX_FRAME_MODE: n.rdata = DATA_W'(s.tx_frame);
        OFS_RX_HOLD: n.rdata = DATA_W'(s.rx_hold);
        OFS_STATUS: n.rdata = DATA_W'(status_word);
        OFS_IRQ_MASK: n.rdata = DATA_W'(s.irq_mask);
        default: n.rdata = '0;  // Unmapped reads zero
      endcase
    end
    if (rd_hold) begin
      n.rx_avail = 1'b0;
    end
    if (rd_status) begin
      n.rx_ovr = 1'b0;
    end
    if (rx_done) begin          // Copy out, overrun if unread
      n.rx_hold = rx_word;
      n.rx_avail = 1'b1;
      if (s.rx_avail && !rd_hold) begin
        n.rx_ovr = 1'b1;
      end
    end

    // Register writes
    if (wr) begin
      case (addr)
        OFS_CTRL: n.ctrl = wdata[1:0];
        OFS_CLK_MODE: n.div_ratio = wdata[DIV_W-1:0];
        OFS_RX_CLK_MODE: n.rx_mode = wdata[MODE_W-1:0];
        OFS_RX_FRAME_MODE: n.rx_frame = wdata[PAT_W-1:0];
        OFS_TX_CLK_MODE: n.tx_mode = wdata[MODE_W-1:0];
        OFS_TX_FRAME_MODE: n.tx_frame = wdata[PAT_W-1:0];
        OFS_TX_HOLD: begin      // New word waits for start
          n.tx_hold = wdata[WORD_BITS-1:0];
          n.tx_full = 1'b1;
        end
        OFS_IRQ_MASK: n.irq_mask = wdata[ST_W-1:0];
        default: n.ctrl = s.ctrl;  // Unmapped writes ignored
      endcase
    end
  end

  // Register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ==================================================
  // Outputs
  assign rdata = s.rdata;
  assign irq = |(status_word & s.irq_mask);
  assign tx_data_pin = s.tx_data;
  assign tx_clock_pin_out = s.tx_sel;
  assign rx_clock_pin_out = s.rx_sel;
  assign tx_clock_pin_oe_n = !(s.tx_mode[CKO_LSB+:2] == CKO_CONT ||
                              (s.tx_mode[CKO_LSB+:2] == CKO_XFER && s.tx_state == TX_SHIFT));
  assign rx_clock_pin_oe_n = !(s.rx_mode[CKO_LSB+:2] == CKO_CONT ||
                              (s.rx_mode[CKO_LSB+:2] == CKO_XFER && s.rx_state == RX_RECV));

  // ==================================================
  // Checks
  property p_tx_load;
    @(posedge clk) disable iff (!reset_n)
      (tx_start && !(wr && addr == OFS_TX_HOLD)) |=> (status_word[ST_TX_FREE] && s.tx_state == TX_SHIFT);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx load did not free holding");

  property p_tx_empty;
    @(posedge clk) disable iff (!reset_n) (s.tx_full || s.tx_state == TX_SHIFT) |-> !status_word[ST_TX_EMPTY];
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty while data held");

  property p_rx_copy;
    @(posedge clk) disable iff (!reset_n) rx_done |=> (s.rx_avail && s.rx_hold == $past(rx_word));
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("rx word not copied");

  property p_rx_ovr;
    @(posedge clk) disable iff (!reset_n) (rx_done && s.rx_avail && !rd_hold) |=> s.rx_ovr;
  endproperty
  a_rx_ovr: assert property (p_rx_ovr) else $error("overrun not flagged");

  property p_tx_cko;
    @(posedge clk) disable iff (!reset_n) (s.tx_mode[CKO_LSB+:2] == CKO_NONE) |-> tx_clock_pin_oe_n;
  endproperty
  a_tx_cko: assert property (p_tx_cko) else $error("tx clock pin driven while input");

  property p_rx_cko;
    @(posedge clk) disable iff (!reset_n)
      (s.rx_mode[CKO_LSB+:2] == CKO_XFER && s.rx_state == RX_IDLE) |-> rx_clock_pin_oe_n;
  endproperty
  a_rx_cko: assert property (p_rx_cko) else $error("rx clock pin driven outside transfer");

  property p_tx_src;
    @(posedge clk) disable iff (!reset_n)
      (s.tx_mode[CKS_LSB+:2] == CKS_PIN) |=> (s.tx_sel == $past(s.sync_b[0]));
  endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx clock not from pin");

  property p_tx_cont;
    @(posedge clk) disable iff (!reset_n)
      (s.tx_mode[START_LSB+:4] == ST_CONT && s.ctrl[CTRL_TX_EN] && s.tx_full && s.tx_state == TX_IDLE && tx_fall)
      |=> s.tx_state == TX_SHIFT;
  endproperty
  a_tx_cont: assert property (p_tx_cont) else $error("continuous tx did not start");

  property p_rx_fall;
    @(posedge clk) disable iff (!reset_n)
      (s.rx_mode[START_LSB+:4] == ST_FALL && s.ctrl[CTRL_RX_EN] && s.rx_state == RX_IDLE && rx_rise &&
       s.rx_fs_prev && !s.sync_b[3]) |=> s.rx_state == RX_RECV;
  endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rx missed falling frame sync");
endmodule
`default_nettype wire

/* test/ssc_peer.sv */
// Behavioural serial peer: captures tx words, sends framed rx words
`default_nettype none
module ssc_peer (
  input wire logic tx_clk,     // Resolved tx clock pin
  input wire logic tx_dat,     // Tx data pin
  input wire logic rx_clk,     // Resolved rx clock pin
  output logic rx_fs,          // Rx frame sync drive
  output logic rx_dat,         // Rx data drive
  output logic [7:0] tx_word   // Last eight tx bits seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================
  // Idle levels at time zero
  initial begin
    rx_fs = 1'b0;
    rx_dat = 1'b0;
    tx_word = 8'h00;
  end
  // Sample tx data on pin rise, MSB first
  always @(posedge tx_clk) begin
    tx_word <= {tx_word[6:0], tx_dat};
  end
  // One word: frame sync pulse, then bits on falling edges
  task automatic send(input logic [7:0] b);
    @(negedge rx_clk);
    rx_fs = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(negedge rx_clk);
      rx_fs = 1'b0;
      rx_dat = b[i];
    end
    @(negedge rx_clk);
    rx_dat = ~rx_dat; // Released line does not hold last bit
  endtask
endmodule
`default_nettype wire

/* test/ssc_core_tb.sv */
// Self-checking bench for the serial controller core
`default_nettype none
module ssc_core_tb
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // Master clock
  logic reset_n = 1'b0; // Reset, active low
  logic [7:0] addr = 8'h00; // Bus address
  logic [31:0] wdata = 32'h0; // Bus write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [31:0] rdata, d; // Read data, scratch
  logic irq, tco, tcoe_n, rco, rcoe_n, tdat, rfs, rdat; // Pins
  logic [7:0] pw, lf = 8'h3f; // Peer word, random state
  logic [7:0] expq[$]; // Reference rx words
  int fails = 0;
  int checked = 0;
  int hi, lo;
  int rat[3] = '{1, 3, 4}; // Divider ratios to measure
  wire tpin = tcoe_n ? 1'b0 : tco; // Tx clock wire
  wire rpin = rcoe_n ? 1'b0 : rco; // Rx clock wire
  always #12.5 clk = ~clk;
  // ==================================================
  // Design and peer
  ssc_core u_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .tx_clock_pin_in(tpin), .tx_clock_pin_out(tco),
    .tx_clock_pin_oe_n(tcoe_n), .rx_clock_pin_in(rpin), .rx_clock_pin_out(rco),
    .rx_clock_pin_oe_n(rcoe_n), .tx_frame_sync_pin(1'b0), .rx_frame_sync_pin(rfs),
    .rx_data_pin(rdat), .tx_data_pin(tdat));
  ssc_peer u_peer (.tx_clk(tpin), .tx_dat(tdat), .rx_clk(rpin), .rx_fs(rfs),
    .rx_dat(rdat), .tx_word(pw));
  // ==================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Poll a status bit with a bound
  task automatic wait_st(input int b);
    for (int n = 0; n < 100; n++) begin
      rd_reg(OFS_STATUS, d);
      if (d[b] === 1'b1) return;
    end
    fails++;
    summarize();
  endtask
  // Width of the next high and low level of tx clock pin
  task automatic meas(output int h, output int l);
    int n;
    n = 0;
    while (tco !== 1'b0 && n < 9000) begin @(posedge clk); n++; end
    while (tco !== 1'b1 && n < 9000) begin @(posedge clk); n++; end
    h = 0;
    l = 0;
    while (tco === 1'b1 && h < 9000) begin @(posedge clk); h++; end
    while (tco === 1'b0 && l < 9000) begin @(posedge clk); l++; end
    if (n >= 9000 || h >= 9000 || l >= 9000) fails++; // Timed out
  endtask
  // ==================================================
  // Watchdog
  initial begin
    #(25 * 60000);
    fails++;
    summarize();
  end
  // ==================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(OFS_STATUS, d);
    chk(d, 32'h3);
    rd_reg(8'h08, d);
    chk(d, 32'h0);
    wr_reg(OFS_CLK_MODE, 32'hffff_ffff);
    rd_reg(OFS_CLK_MODE, d);
    chk(d, 32'hfff);
    lf = lfsr(lf);
    wr_reg(OFS_IRQ_MASK, {24'h0, lf});
    rd_reg(OFS_IRQ_MASK, d);
    chk(d, {24'h0, lf});
    wr_reg(OFS_IRQ_MASK, 32'h10);
    // Divider on tx pin, continuous output
    wr_reg(OFS_TX_CLK_MODE, {20'h0, ST_CONT, 3'h0, 1'b0, CKO_CONT, CKS_DIV});
    @(negedge clk);
    chk(tcoe_n, 1'b0);
    foreach (rat[i]) begin
      wr_reg(OFS_CLK_MODE, rat[i]);
      meas(hi, lo);
      chk(hi, rat[i]);
      chk(lo, rat[i]);
    end
    wr_reg(OFS_CLK_MODE, 32'h0);
    repeat (4) @(posedge clk);
    d[0] = tco;
    hi = 0;
    repeat (40) begin @(posedge clk); if (tco !== d[0]) hi++; end
    chk(hi, 0);
    // Transmit one random word, clock only during transfer
    wr_reg(OFS_CLK_MODE, 32'h4);
    wr_reg(OFS_TX_CLK_MODE, {20'h0, ST_CONT, 3'h0, 1'b0, CKO_XFER, CKS_DIV});
    wr_reg(OFS_CTRL, 32'h2);
    lf = lfsr(lf);
    wr_reg(OFS_TX_HOLD, {24'h0, lf});
    wait_st(ST_TX_FREE);
    wait_st(ST_TX_EMPTY);
    repeat (10) @(posedge clk);
    chk(pw, lf);
    chk(tcoe_n, 1'b1);
    // Receive two words on frame sync rise, first left unread, clock borrowed from tx
    wr_reg(OFS_RX_CLK_MODE, {20'h0, ST_RISE, 3'h0, 1'b0, CKO_CONT, CKS_OTHER});
    wr_reg(OFS_CTRL, 32'h3);
    chk(rcoe_n, 1'b0);
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      expq.push_back(lf);
      u_peer.send(lf);
      if (k == 0) wait_st(ST_RX_AVAIL);
    end
    repeat (4) @(posedge clk);
    chk(irq, 1'b1);
    rd_reg(OFS_STATUS, d);
    chk(d[5:4], 2'h3);
    void'(expq.pop_front());
    rd_reg(OFS_RX_HOLD, d);
    chk(d, {24'h0, expq.pop_front()});
    rd_reg(OFS_STATUS, d);
    chk(d[5:4], 2'h0);
    chk(irq, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
